// >>> verilog/amss_consts.svh
// Constants of the asynchronous memory strobe sequencer: widths, offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AMSS_CONSTS_SVH
`define AMSS_CONSTS_SVH

// Widths of the memory side, of the register port and of the phase counters.
`define AMSS_CNT_W 8
`define AMSS_CE_W 4
`define AMSS_CS_W 2
`define AMSS_BE_W 2
`define AMSS_ADDR_W 20
`define AMSS_DATA_W 16
`define AMSS_REG_AW 8
`define AMSS_REG_DW 32

// Register offsets, byte addresses on the plain register port.
`define AMSS_OFF_RD_TIMING 8'h00
`define AMSS_OFF_WR_TIMING 8'h04
`define AMSS_OFF_ADDRESS 8'h08
`define AMSS_OFF_WDATA 8'h0c
`define AMSS_OFF_COMMAND 8'h10
`define AMSS_OFF_STATUS 8'h14
`define AMSS_OFF_RDATA 8'h18

// Field positions inside the timing, command and status registers.
`define AMSS_F_SETUP_LSB 0
`define AMSS_F_STROBE_LSB 8
`define AMSS_F_HOLD_LSB 16
`define AMSS_F_CMD_WRITE 0
`define AMSS_F_CMD_CS_LSB 2
`define AMSS_F_CMD_BE_LSB 4
`define AMSS_F_STAT_BUSY 0
`define AMSS_F_STAT_READY 1

// Reset values of the timing registers.
`define AMSS_RST_SETUP 8'h01
`define AMSS_RST_STROBE 8'h04
`define AMSS_RST_HOLD 8'h01

// Counter landmarks: last cycle of a phase and the ready sampling point.
`define AMSS_CNT_LAST 8'h01
`define AMSS_READY_POINT 8'h02
`define AMSS_CNT_ZERO 8'h00

// Idle levels of the pins and the one-hot base of the chip enable decode.
`define AMSS_CE_IDLE 4'hf
`define AMSS_CE_ONE 4'h1
`define AMSS_BE_IDLE 2'h3
`endif

// >>> verilog/amss_pkg.sv
// Types shared by the asynchronous memory strobe sequencer.
// Assumes amss_consts.svh is on the include path.
`include "amss_consts.svh"

package amss_pkg;
	// Phases of one asynchronous access.
	typedef enum logic [1:0] {
		AMSS_IDLE,
		AMSS_SETUP,
		AMSS_STROBE,
		AMSS_HOLD
	} amss_state_e;

	// One set of setup, strobe and hold counts.
	typedef struct packed {
		logic [`AMSS_CNT_W-1:0] hold;
		logic [`AMSS_CNT_W-1:0] strobe;
		logic [`AMSS_CNT_W-1:0] setup;
	} amss_timing_s;

	// Select group driven toward the memory.
	typedef struct packed {
		logic [`AMSS_CE_W-1:0] chip_enable_n;
		logic [`AMSS_BE_W-1:0] byte_enable_n;
		logic [`AMSS_ADDR_W-1:0] ext_address;
		logic output_enable_n;
	} amss_sel_s;
endpackage : amss_pkg

// >>> verilog/amss_sync.sv
// Two-stage level synchroniser with a clock enable.
// Assumes a single clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module amss_sync
	import amss_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	// Asynchronous level in, synchronised level out.
	input wire logic d,
	output logic q
);
	logic meta_r;
	logic q_r;

	// First stage feeds only the second stage.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b1;
			q_r <= 1'b1;
		end else if (en) begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;

	// The output follows the input two enabled edges later.
	property p_sync_delay;
		@(posedge clk) disable iff (rst || !en)
		en ##1 en |-> q == $past(d, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("ready synchroniser delay wrong");
endmodule : amss_sync

`default_nettype wire

// >>> verilog/amss_seq.sv
// Asynchronous memory strobe sequencer of the narrow 16-bit memory port.
// Assumes CORE_CLK is also the memory output clock, so one cycle is one memory clock period.
//
// Summary of operation
// - Setup, strobe and hold are counted in whole memory clock periods.
// - Six counts are programmed: read and write setup, strobe and hold.
// - Read: select signals valid for read setup periods before read strobe falls.
// - Read: select signals stay valid for read hold periods after strobe rises.
// - Write: select signals and data valid for write setup before write strobe.
// - Write: select signals and data stay valid for write hold after strobe.
// - Select group: chip enables, byte enables, address, output enable, write data.
// - Shared control pins act only as output enable, read and write strobe.
// - Read data is captured at the edge that ends the read strobe.
// - The ready input passes a two-stage synchroniser before use.
// - Ready is evaluated only two cycles before the strobe would end.
// - While ready is low the strobe stretches one cycle at a time.
// - After ready returns high the strobe ends two cycles later.
// - Ready is sampled on rising edges of the memory clock.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "amss_consts.svh"

module amss_seq
	import amss_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic CLK_EN,
	// Register port.
	input wire logic [`AMSS_REG_AW-1:0] REG_ADDR,
	input wire logic [`AMSS_REG_DW-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [`AMSS_REG_DW-1:0] REG_RDATA,
	// Select group toward the memory.
	output logic [`AMSS_CE_W-1:0] CHIP_ENABLE_N,
	output logic [`AMSS_BE_W-1:0] BYTE_ENABLE_N,
	output logic [`AMSS_ADDR_W-1:0] EXT_ADDRESS,
	output logic OUTPUT_ENABLE_N,
	// Strobes.
	output logic READ_STROBE_N,
	output logic WRITE_STROBE_N,
	// Two-way data bus and ready.
	input wire logic [`AMSS_DATA_W-1:0] EXT_DATA_IN,
	output logic [`AMSS_DATA_W-1:0] EXT_DATA_OUT,
	output logic EXT_DATA_OE,
	input wire logic EXT_READY_IN
);
	// A programmed count of zero is taken as one period.
	function automatic logic [`AMSS_CNT_W-1:0] amss_eff(input logic [`AMSS_CNT_W-1:0] n);
		return (n == `AMSS_CNT_ZERO) ? `AMSS_CNT_LAST : n;
	endfunction : amss_eff

	amss_timing_s rd_timing_r;
	amss_timing_s wr_timing_r;
	amss_timing_s cur_timing_r;
	logic [`AMSS_ADDR_W-1:0] addr_r;
	logic [`AMSS_DATA_W-1:0] wdata_r;
	logic [`AMSS_DATA_W-1:0] rdata_r;
	logic [`AMSS_CS_W-1:0] cs_r;
	logic [`AMSS_BE_W-1:0] be_r;
	logic wr_dir_r;
	amss_state_e state_r;
	amss_state_e state_nxt;
	logic [`AMSS_CNT_W-1:0] cnt_r;
	logic [`AMSS_CNT_W-1:0] cnt_nxt;
	amss_sel_s sel_r;
	amss_sel_s sel_nxt;
	logic rd_n_r;
	logic we_n_r;
	logic [`AMSS_DATA_W-1:0] dout_r;
	logic doe_r;
	logic [`AMSS_REG_DW-1:0] reg_rdata_r;
	logic ready_s;

	// Ready crosses a two-stage synchroniser on the memory clock.
	amss_sync u_ready_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.en(CLK_EN),
		.d(EXT_READY_IN),
		.q(ready_s)
	);

	// Register decode and command acceptance.
	wire idle = (state_r == AMSS_IDLE);
	wire wr_rd_timing = REG_WR && (REG_ADDR == `AMSS_OFF_RD_TIMING);
	wire wr_wr_timing = REG_WR && (REG_ADDR == `AMSS_OFF_WR_TIMING);
	wire wr_address = REG_WR && (REG_ADDR == `AMSS_OFF_ADDRESS);
	wire wr_wdata = REG_WR && (REG_ADDR == `AMSS_OFF_WDATA);
	wire start = REG_WR && (REG_ADDR == `AMSS_OFF_COMMAND) && idle;
	wire cmd_write = REG_WDATA[`AMSS_F_CMD_WRITE];
	wire [`AMSS_CS_W-1:0] cmd_cs = REG_WDATA[`AMSS_F_CMD_CS_LSB +: `AMSS_CS_W];
	wire [`AMSS_BE_W-1:0] cmd_be = REG_WDATA[`AMSS_F_CMD_BE_LSB +: `AMSS_BE_W];
	wire amss_timing_s new_timing = {REG_WDATA[`AMSS_F_HOLD_LSB +: `AMSS_CNT_W],
		REG_WDATA[`AMSS_F_STROBE_LSB +: `AMSS_CNT_W],
		REG_WDATA[`AMSS_F_SETUP_LSB +: `AMSS_CNT_W]};
	wire amss_timing_s start_timing = cmd_write ? wr_timing_r : rd_timing_r;

	// Read data selection; unmapped offsets read as zero.
	wire [`AMSS_REG_DW-1:0] status_word = {{(`AMSS_REG_DW-2){1'b0}}, ready_s, ~idle};
	wire [`AMSS_REG_DW-1:0] cmd_word = {{(`AMSS_REG_DW-6){1'b0}}, be_r, cs_r, 1'b0, wr_dir_r};
	wire [`AMSS_REG_DW-1:0] rd_mux =
		(REG_ADDR == `AMSS_OFF_RD_TIMING) ? {{(`AMSS_REG_DW-24){1'b0}}, rd_timing_r} :
		(REG_ADDR == `AMSS_OFF_WR_TIMING) ? {{(`AMSS_REG_DW-24){1'b0}}, wr_timing_r} :
		(REG_ADDR == `AMSS_OFF_ADDRESS) ? {{(`AMSS_REG_DW-`AMSS_ADDR_W){1'b0}}, addr_r} :
		(REG_ADDR == `AMSS_OFF_WDATA) ? {{(`AMSS_REG_DW-`AMSS_DATA_W){1'b0}}, wdata_r} :
		(REG_ADDR == `AMSS_OFF_COMMAND) ? cmd_word :
		(REG_ADDR == `AMSS_OFF_STATUS) ? status_word :
		(REG_ADDR == `AMSS_OFF_RDATA) ? {{(`AMSS_REG_DW-`AMSS_DATA_W){1'b0}}, rdata_r} :
		{`AMSS_REG_DW{1'b0}};

	// Phase sequencing; every count is one memory clock period per step.
	wire last = (cnt_r == `AMSS_CNT_LAST);
	wire at_ready_point = (cnt_r == `AMSS_READY_POINT);
	wire capture = (state_r == AMSS_STROBE) && last && !wr_dir_r;
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			AMSS_IDLE: begin
				if (start) begin
					state_nxt = AMSS_SETUP;
					cnt_nxt = amss_eff(start_timing.setup);
				end
			end
			AMSS_SETUP: begin
				if (last) begin
					state_nxt = AMSS_STROBE;
					cnt_nxt = amss_eff(cur_timing_r.strobe);
				end else begin
					cnt_nxt = cnt_r - `AMSS_CNT_LAST;
				end
			end
			AMSS_STROBE: begin
				if (last) begin
					state_nxt = AMSS_HOLD;
					cnt_nxt = amss_eff(cur_timing_r.hold);
				end else if (at_ready_point && !ready_s) begin
					cnt_nxt = cnt_r;
				end else begin
					cnt_nxt = cnt_r - `AMSS_CNT_LAST;
				end
			end
			AMSS_HOLD: begin
				if (last) begin
					state_nxt = AMSS_IDLE;
					cnt_nxt = `AMSS_CNT_ZERO;
				end else begin
					cnt_nxt = cnt_r - `AMSS_CNT_LAST;
				end
			end
			default: begin
				state_nxt = AMSS_IDLE;
				cnt_nxt = `AMSS_CNT_ZERO;
			end
		endcase
	end

	// Next pin levels; the select group is valid through all three phases.
	wire active_nxt = (state_nxt != AMSS_IDLE);
	wire strobe_nxt = (state_nxt == AMSS_STROBE);
	wire [`AMSS_CS_W-1:0] cs_use = idle ? cmd_cs : cs_r;
	wire [`AMSS_BE_W-1:0] be_use = idle ? cmd_be : be_r;
	wire wr_use = idle ? cmd_write : wr_dir_r;
	wire [`AMSS_CE_W-1:0] ce_dec = ~(`AMSS_CE_ONE << cs_use);
	// One driver for the whole select word, fields in struct order.
	assign sel_nxt = {active_nxt ? ce_dec : `AMSS_CE_IDLE,
		active_nxt ? ~be_use : `AMSS_BE_IDLE,
		addr_r,
		!(active_nxt && !wr_use)};

	// Register file and command latches.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			rd_timing_r <= {`AMSS_RST_HOLD, `AMSS_RST_STROBE, `AMSS_RST_SETUP};
			wr_timing_r <= {`AMSS_RST_HOLD, `AMSS_RST_STROBE, `AMSS_RST_SETUP};
			cur_timing_r <= {`AMSS_RST_HOLD, `AMSS_RST_STROBE, `AMSS_RST_SETUP};
			addr_r <= '0;
			wdata_r <= '0;
			cs_r <= '0;
			be_r <= '0;
			wr_dir_r <= 1'b0;
			rdata_r <= '0;
			reg_rdata_r <= '0;
		end else if (CLK_EN) begin
			if (wr_rd_timing) rd_timing_r <= new_timing;
			if (wr_wr_timing) wr_timing_r <= new_timing;
			if (wr_address && idle) addr_r <= REG_WDATA[`AMSS_ADDR_W-1:0];
			if (wr_wdata && idle) wdata_r <= REG_WDATA[`AMSS_DATA_W-1:0];
			if (start) begin
				cur_timing_r <= start_timing;
				cs_r <= cmd_cs;
				be_r <= cmd_be;
				wr_dir_r <= cmd_write;
			end
			if (capture) rdata_r <= EXT_DATA_IN;
			reg_rdata_r <= REG_RD ? rd_mux : '0;
		end
	end

	// Sequencer state and registered pins.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			state_r <= AMSS_IDLE;
			cnt_r <= `AMSS_CNT_ZERO;
			sel_r <= {`AMSS_CE_IDLE, `AMSS_BE_IDLE, {`AMSS_ADDR_W{1'b0}}, 1'b1};
			rd_n_r <= 1'b1;
			we_n_r <= 1'b1;
			dout_r <= '0;
			doe_r <= 1'b0;
		end else if (CLK_EN) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sel_r <= sel_nxt;
			rd_n_r <= !(strobe_nxt && !wr_use);
			we_n_r <= !(strobe_nxt && wr_use);
			dout_r <= wdata_r;
			doe_r <= active_nxt && wr_use;
		end
	end

	// Pins come straight from the flip-flops.
	assign CHIP_ENABLE_N = sel_r.chip_enable_n;
	assign BYTE_ENABLE_N = sel_r.byte_enable_n;
	assign EXT_ADDRESS = sel_r.ext_address;
	assign OUTPUT_ENABLE_N = sel_r.output_enable_n;
	assign READ_STROBE_N = rd_n_r;
	assign WRITE_STROBE_N = we_n_r;
	assign EXT_DATA_OUT = dout_r;
	assign EXT_DATA_OE = doe_r;
	assign REG_RDATA = reg_rdata_r;

	// Helper counters measuring setup and hold at the pins.
	wire sel_act = ~&CHIP_ENABLE_N;
	wire strobes_high = READ_STROBE_N && WRITE_STROBE_N;
	logic seen_strobe_r;
	logic [`AMSS_CNT_W-1:0] pre_cnt_r;
	logic [`AMSS_CNT_W-1:0] post_cnt_r;
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			seen_strobe_r <= 1'b0;
			pre_cnt_r <= `AMSS_CNT_ZERO;
			post_cnt_r <= `AMSS_CNT_ZERO;
		end else if (CLK_EN) begin
			seen_strobe_r <= sel_act && (seen_strobe_r || !strobes_high);
			pre_cnt_r <= (sel_act && strobes_high && !seen_strobe_r) ?
				pre_cnt_r + `AMSS_CNT_LAST : (sel_act ? pre_cnt_r : `AMSS_CNT_ZERO);
			post_cnt_r <= (sel_act && strobes_high && seen_strobe_r) ?
				post_cnt_r + `AMSS_CNT_LAST : (sel_act ? post_cnt_r : `AMSS_CNT_ZERO);
		end
	end

	// Read setup measured at the pins equals the latched count.
	property p_rd_setup;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		$fell(READ_STROBE_N) |-> pre_cnt_r == amss_eff(cur_timing_r.setup);
	endproperty
	a_rd_setup: assert property (p_rd_setup) else $error("read setup length wrong");

	// Read hold measured at the pins equals the latched count.
	property p_rd_hold;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		$rose(&CHIP_ENABLE_N) && !wr_dir_r |-> post_cnt_r == amss_eff(cur_timing_r.hold);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read hold length wrong");

	// Write setup with data driven for the latched count.
	property p_wr_setup;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		$fell(WRITE_STROBE_N) |-> pre_cnt_r == amss_eff(cur_timing_r.setup) && EXT_DATA_OE;
	endproperty
	a_wr_setup: assert property (p_wr_setup) else $error("write setup length wrong");

	// Write hold with data still driven until select drops.
	property p_wr_hold;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		$rose(&CHIP_ENABLE_N) && wr_dir_r |->
			post_cnt_r == amss_eff(cur_timing_r.hold) && $past(EXT_DATA_OE);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write hold length wrong");

	// Read strobe and write strobe are never low together.
	property p_one_strobe;
		@(posedge CORE_CLK) disable iff (RESET)
		!(!READ_STROBE_N && !WRITE_STROBE_N) && (READ_STROBE_N || !OUTPUT_ENABLE_N);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap");

	// Read data is the bus value at the edge that ends the strobe.
	property p_capture;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		$rose(READ_STROBE_N) |-> rdata_r == $past(EXT_DATA_IN);
	endproperty
	a_capture: assert property (p_capture) else $error("read data not captured");

	// Away from the ready point the strobe counts down regardless of ready.
	property p_ignore_ready;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		state_r == AMSS_STROBE && cnt_r > `AMSS_READY_POINT |=> cnt_r == $past(cnt_r) - 8'h01;
	endproperty
	a_ignore_ready: assert property (p_ignore_ready) else $error("ready seen off point");

	// Ready low at the point holds the strobe one more cycle.
	property p_stretch;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		state_r == AMSS_STROBE && at_ready_point && !ready_s |=>
			state_r == AMSS_STROBE && at_ready_point && !(READ_STROBE_N && WRITE_STROBE_N);
	endproperty
	a_stretch: assert property (p_stretch) else $error("strobe not stretched");

	// Ready high at the point ends the strobe two cycles later.
	property p_end_after_ready;
		@(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
		state_r == AMSS_STROBE && at_ready_point && ready_s |->
			##1 (!READ_STROBE_N || !WRITE_STROBE_N) ##1 strobes_high;
	endproperty
	a_end_after_ready: assert property (p_end_after_ready) else $error("strobe end late");
endmodule : amss_seq

`default_nettype wire

// >>> dv/amss_mem_model.sv
// Behavioural asynchronous SRAM that sits on the far side of the strobe sequencer.
// Assumes the bench resolves the data bus and sets the ready stall length per access.
`timescale 1ns/1ps
`default_nettype none

module amss_mem_model (
	// Memory clock.
	input wire logic clk,
	// Select group and strobes from the controller.
	input wire logic [3:0] ce_n,
	input wire logic [19:0] addr,
	input wire logic oe_n,
	input wire logic rd_n,
	input wire logic wr_n,
	// Resolved data bus and stall length chosen by the bench.
	input wire logic [15:0] bus,
	input wire logic [7:0] wait_len,
	// Read data and ready toward the controller.
	output logic [15:0] rd_data,
	output logic ready
);
	logic [15:0] mem [256];
	logic [15:0] last_r = 16'h0000;
	logic [7:0] cnt_r = 8'h00;
	wire logic sel = (ce_n != 4'hf);
	wire logic drive = sel && !oe_n && !rd_n;

	// The word shows only while selected and strobed, held 1 ns past the strobe's end.
	// Outside that the bus flips every cycle so a late capture cannot pass by luck.
	assign #1 rd_data = drive ? mem[addr[7:0]] : ~last_r;
	always @(posedge clk) last_r <= rd_data;

	// Write data is taken at the rising write strobe while the bus is still held.
	always @(posedge wr_n) if (sel) mem[addr[7:0]] <= bus;

	// Ready stays low for wait_len clocks of each strobe; the bench never asks for 1.
	initial ready = 1'b1;
	always @(negedge clk) begin
		if (sel && !(rd_n && wr_n)) begin
			ready <= (cnt_r >= wait_len);
			cnt_r <= cnt_r + 8'h01;
		end else begin
			ready <= 1'b1;
			cnt_r <= 8'h00;
		end
	end
endmodule : amss_mem_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the asynchronous memory strobe sequencer.
// Assumes the design files and amss_mem_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "amss_consts.svh"

module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rv;
	logic [3:0] ce_n;
	logic [1:0] be_n;
	logic [19:0] ext_addr;
	logic oe_n, rd_n, wr_n, data_oe, ready;
	logic [15:0] data_out, data_in, mem_drive;
	logic [7:0] wait_len = 8'h00;
	integer seed = 32'h4077;
	int num_errors = 0;
	int cmp_count = 0;
	logic [15:0] exp_mem [int];
	logic [19:0] addr_q [$];

	// The controller wins the bus while it drives, otherwise the memory does.
	assign data_in = data_oe ? data_out : mem_drive;

	amss_seq u_dut (.CORE_CLK(clk), .RESET(rst), .CLK_EN(clk_en), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.CHIP_ENABLE_N(ce_n), .BYTE_ENABLE_N(be_n), .EXT_ADDRESS(ext_addr),
		.OUTPUT_ENABLE_N(oe_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
		.EXT_DATA_IN(data_in), .EXT_DATA_OUT(data_out), .EXT_DATA_OE(data_oe),
		.EXT_READY_IN(ready));

	amss_mem_model u_mem (.clk(clk), .ce_n(ce_n), .addr(ext_addr), .oe_n(oe_n), .rd_n(rd_n),
		.wr_n(wr_n), .bus(data_in), .wait_len(wait_len), .rd_data(mem_drive), .ready(ready));

	// Free-running 20 MHz clock.
	initial begin
		forever #25 clk = ~clk;
	end

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// One-cycle register write; an edge passes first so the strobe never drops and rises at once.
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : bus_write

	// One-cycle register read; data is taken mid-cycle of the following clock.
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask : bus_read

	// Runs one access, measures its phases and checks the select group every cycle.
	task automatic access(input logic wr, input logic [1:0] cs, input logic [1:0] be,
		input logic [7:0] s, input logic [7:0] p, input logic [7:0] h, input logic [7:0] w,
		input logic poke);
		logic [19:0] a;
		logic [15:0] d;
		logic [3:0] ece;
		logic [31:0] v;
		int ns, np, nh, n;
		int es = (s == 8'h00) ? 1 : int'(s);
		int ep = (p == 8'h00) ? 1 : int'(p);
		int eh = (h == 8'h00) ? 1 : int'(h);
		a = wr ? (20'($random(seed)) & 20'h000ff) : addr_q.pop_front();
		d = 16'($random(seed));
		ece = ~(4'h1 << cs);
		ns = 0;
		np = 0;
		nh = 0;
		n = 0;
		wait_len <= w;
		bus_write(wr ? `AMSS_OFF_WR_TIMING : `AMSS_OFF_RD_TIMING, {8'h00, h, p, s});
		bus_write(`AMSS_OFF_ADDRESS, {12'h000, a});
		bus_write(`AMSS_OFF_WDATA, {16'h0000, d});
		bus_write(`AMSS_OFF_COMMAND, {26'h0, be, cs, 1'b0, wr});
		fork
			if (poke) begin
				@(posedge clk);
				bus_write(`AMSS_OFF_ADDRESS, 32'h000fffff);
			end
			begin
				while (ce_n === 4'hf && n < 8) begin
					@(negedge clk);
					n++;
				end
				while (ce_n !== 4'hf && n < 3000) begin
					chk({ce_n, be_n, ext_addr, oe_n, data_oe}, {ece, ~be, a, wr, wr});
					if (wr) chk(data_out, d);
					chk(wr ? rd_n : wr_n, 1'b1);
					if (!rd_n || !wr_n) np++;
					else if (np == 0) ns++;
					else nh++;
					@(negedge clk);
					n++;
				end
			end
		join
		chk(ns, es);
		chk(nh, eh);
		// Ready is looked at one edge before the strobe's last edge and arrives two edges late.
		if (w == 8'h00 || ep < 4) chk(np, ep);
		else chk(np, (ep > int'(w) + 4) ? ep : int'(w) + 4);
		@(posedge clk);
		bus_read(`AMSS_OFF_STATUS, v);
		chk(v[0], 1'b0);
		if (wr) begin
			exp_mem[int'(a)] = d;
			addr_q.push_back(a);
		end else begin
			bus_read(`AMSS_OFF_RDATA, v);
			chk(v[15:0], exp_mem[int'(a)]);
		end
	endtask : access

	// Prints the verdict and ends the run.
	task automatic results;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// Main sequence: reset values, every chip select and byte lane, stalls, random mix.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus_read(`AMSS_OFF_RD_TIMING, rv);
		chk(rv, 32'h00010401);
		bus_read(`AMSS_OFF_WR_TIMING, rv);
		chk(rv, 32'h00010401);
		bus_read(8'h1c, rv);
		chk(rv, 32'h0);
		for (int i = 0; i < 4; i++) begin
			access(1'b1, 2'(i), 2'(i), 8'(i), 8'(i + 2), 8'(i), 8'h00, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			access(1'b0, 2'(i), 2'(3 - i), 8'(i + 1), 8'h04, 8'(3 - i), 8'h00, i == 1);
		end
		access(1'b1, 2'h1, 2'h3, 8'h02, 8'h04, 8'h01, 8'h06, 1'b0);
		access(1'b0, 2'h2, 2'h3, 8'h01, 8'h06, 8'h02, 8'h05, 1'b0);
		access(1'b1, 2'h3, 2'h1, 8'h01, 8'h01, 8'h01, 8'h06, 1'b0);
		access(1'b0, 2'h0, 2'h3, 8'h00, 8'h00, 8'h00, 8'h04, 1'b0);
		for (int i = 0; i < 6; i++) begin
			rv = $random(seed);
			access(1'b1, rv[1:0], rv[3:2], {5'h0, rv[6:4]}, {5'h0, rv[9:7]} + 8'h01,
				{5'h0, rv[12:10]}, 8'h00, 1'b0);
			access(1'b0, rv[3:2], rv[1:0], {5'h0, rv[9:7]}, {5'h0, rv[6:4]} + 8'h04,
				{5'h0, rv[15:13]}, rv[16] ? 8'h00 : {5'h0, rv[19:17]} + 8'h02, 1'b0);
		end
		results();
	end

	// Watchdog: the run needs about six hundred cycles, so 20000 means a hang.
	initial begin
		#1000000;
		num_errors++;
		results();
	end
endmodule : tb_top
`default_nettype wire
